// file: port_write_retry_pkg.sv
// Shared constants and types for the port-write retry and event pin block
package port_write_retry_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [16:0] EVENT_PIN_CONTROL_ADDR     = 17'h130D0;
  localparam logic [16:0] REPORT_RETRY_TIMEOUT_ADDR  = 17'h1AC14;
  localparam logic [16:0] PENDING_REPORT_STATUS_ADDR = 17'h1AC18;
  localparam logic [16:0] ERROR_DETECT_CLEAR_ADDR    = 17'h1AC1C;
  localparam logic [16:0] IRQ_STATUS_ADDR            = 17'h1AC20;
  localparam logic [16:0] IRQ_MASK_ADDR              = 17'h1AC24;

  // ==========================================================================
  // Field positions (bit 0 of the big-endian layout is bit 31 here)
  localparam int RETRY_CODE_LSB = 28;
  localparam int RETRY_CODE_W   = 4;
  localparam int PIN_DIR_LSB    = 28;
  localparam int PIN_DIR_W      = 2;
  localparam int PORT_COUNT     = 8;
  localparam int IRQ_W          = 3;
  localparam int IRQ_SENT_BIT   = 0;
  localparam int IRQ_PIN_IN_BIT = 1;
  localparam int IRQ_PIN_OUT_BIT = 2;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] EVENT_PIN_CONTROL_RST    = 32'h0000_0000;
  localparam logic [31:0] REPORT_RETRY_TIMEOUT_RST = 32'h0000_0000;
  localparam logic [7:0]  PENDING_STATUS_RST       = 8'h00;
  localparam logic [2:0]  IRQ_RST                  = 3'h0;

  // ==========================================================================
  // Timing
  localparam longint CLK_PERIOD_NS   = 10;
  localparam longint RETRY_UNIT_NS   = 167772160;
  localparam longint DEBUG_PERIOD_NS = 1300;
  localparam int     EXTRA_CYCLES    = 2;
  localparam int     RETRY_UNIT_CYCLES = int'(RETRY_UNIT_NS / CLK_PERIOD_NS);
  localparam int     DEBUG_CYCLES    = int'(DEBUG_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [3:0] RETRY_OFF   = 4'h0;
  localparam logic [3:0] RETRY_DEBUG = 4'hF;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PIN_OFF = 2'h0,
    PIN_IN  = 2'h1,
    PIN_OUT = 2'h2,
    PIN_RSV = 2'h3
  } pin_dir_e;

  typedef struct packed {
    logic       sent;
    logic [2:0] port;
  } arb_sent_s;

endpackage : port_write_retry_pkg

// file: retry_timer.sv
// Retry timer that repeats error-reporting port-writes
`timescale 1ns/1ps
module retry_timer #(
  parameter int UNIT_CYCLES = port_write_retry_pkg::RETRY_UNIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [3:0] code,
  output logic            fire
);

  typedef enum logic [1:0] {
    IDLE = 2'b01,
    RUN  = 2'b10
  } timer_state_e;

  timer_state_e state;
  logic [31:0]  count;
  logic [31:0]  since;

  // Period in cycles for a code; debug code is a short fixed period
  function automatic logic [31:0] period_of(input logic [3:0] c);
    logic [31:0] p;
    p = 32'(c) * 32'(UNIT_CYCLES) + 32'(port_write_retry_pkg::EXTRA_CYCLES);
    if (c == port_write_retry_pkg::RETRY_DEBUG) begin
      p = 32'(port_write_retry_pkg::DEBUG_CYCLES);
    end
    return p;
  endfunction : period_of

  wire logic        start  = (state == IDLE) && enable && (code != port_write_retry_pkg::RETRY_OFF);
  wire logic        expire = (state == RUN) && (count == 32'h1);
  wire logic [31:0] period = period_of(code);

  // ==========================================================================
  // Timer: a stop request wins over expiry, so no send follows a clear
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= IDLE;
      count <= 32'h0;
      fire  <= 1'b0;
    end else begin
      fire <= 1'b0;
      case (state)
        IDLE: begin
          if (start) begin
            state <= RUN;
            count <= period - 32'h2; // The first send left one cycle before this load, and PW_SEND lags fire by one
          end
        end
        RUN: begin
          if (!enable || code == port_write_retry_pkg::RETRY_OFF) begin
            state <= IDLE;
          end else if (expire) begin
            fire  <= 1'b1;
            count <= period;
          end else begin
            count <= count - 32'h1;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Cycles since the last send, watched by the period check only
  always_ff @(posedge clk) begin
    if (reset) since <= 32'h0;
    else if (start) since <= 32'h3;
    else if (expire) since <= 32'h1;
    else since <= since + 32'h1;
  end

  a_period_exact: assert property (@(posedge clk) disable iff (reset)
    expire && enable && $stable(code) |-> since == period)
    else $error("retry period does not match the code");

  a_zero_no_fire: assert property (@(posedge clk) disable iff (reset)
    (code == port_write_retry_pkg::RETRY_OFF) [*2] |=> !fire)
    else $error("retry fired with repetition disabled");

  a_start_runs: assert property (@(posedge clk) disable iff (reset)
    start |=> state == RUN)
    else $error("timer did not start for a pending report");

endmodule : retry_timer

// file: port_write_retry.sv
// Port-write retry timer, pending request status and event pin control
`timescale 1ns/1ps
// How it works
// - Timer starts whenever an error-reporting port-write is pending and the retry code is not zero.
// - On expiry with report still pending, send again and restart timer.
// - Software write to error-detect register clears pending report, stopping repeats.
// - Period is code times base unit plus two clock cycles.
// - Period counted on the 100 MHz register clock.
// - Code zero disables repetition; one port-write per error event.
// - Codes 1,2,4,8 give 167.7 ms to 1.34 s; 15 is debug; others reserved.
// - After a send, mark every port whose request still waits.
// - Pending vector in low eight bits, port 0 at lowest bit, read-only.
// - Direction 00 makes the event pin ignored both ways.
// - Direction 01 makes the pin an input triggering a multicast symbol.
// - Direction 10 drives the pin on symbol reception; 11 reserved.
module port_write_retry #(
  parameter int UNIT_CYCLES = port_write_retry_pkg::RETRY_UNIT_CYCLES,
  parameter int PORTS       = port_write_retry_pkg::PORT_COUNT
) (
  input  wire logic                           CLK_SYS,
  input  wire logic                           RESET,
  input  wire logic [16:0]                    ADDR,
  input  wire logic [31:0]                    WR_DATA,
  input  wire logic                           WR_EN,
  input  wire logic                           RD_EN,
  output logic      [31:0]                    RD_DATA,
  output logic                                IRQ,
  input  wire logic                           ERR_EVENT,
  output logic                                PW_SEND,
  input  wire logic [PORTS-1:0]               PW_REQ,
  input  wire port_write_retry_pkg::arb_sent_s ARB_SENT,
  input  wire logic                           SYM_RECEIVED,
  output logic                                SYM_GENERATE,
  input  wire logic                           MC_EVENT_PIN_I,
  output logic                                MC_EVENT_PIN_O,
  output logic                                MC_EVENT_PIN_OE
);

  // ==========================================================================
  // Register state
  logic [31:0]                retry_reg;
  logic [31:0]                pin_reg;
  logic [PORTS-1:0]           pending_report_per_port;
  logic [port_write_retry_pkg::IRQ_W-1:0] irq_status;
  logic [port_write_retry_pkg::IRQ_W-1:0] irq_mask;
  logic                       report_pending;
  logic                       pin_prev;
  logic                       retry_fire;

  // ==========================================================================
  // Address decode
  wire logic wr_retry = WR_EN && ADDR == port_write_retry_pkg::REPORT_RETRY_TIMEOUT_ADDR;
  wire logic wr_pin   = WR_EN && ADDR == port_write_retry_pkg::EVENT_PIN_CONTROL_ADDR;
  wire logic wr_clear = WR_EN && ADDR == port_write_retry_pkg::ERROR_DETECT_CLEAR_ADDR;
  wire logic wr_mask  = WR_EN && ADDR == port_write_retry_pkg::IRQ_MASK_ADDR;
  wire logic rd_irq   = RD_EN && ADDR == port_write_retry_pkg::IRQ_STATUS_ADDR;

  // Field extraction
  wire logic [3:0] retry_interval_code =
    retry_reg[port_write_retry_pkg::RETRY_CODE_LSB +: port_write_retry_pkg::RETRY_CODE_W];
  wire port_write_retry_pkg::pin_dir_e event_pin_direction =
    port_write_retry_pkg::pin_dir_e'(
      pin_reg[port_write_retry_pkg::PIN_DIR_LSB +: port_write_retry_pkg::PIN_DIR_W]);

  // Write masks keep reserved bits at zero
  wire logic [31:0] retry_wmask = {4'hF, 28'h0000000};
  wire logic [31:0] pin_wmask   = {2'h0, 2'h3, 28'h0000000};

  // ==========================================================================
  // Read multiplexer; unmapped addresses read as zero
  wire logic [31:0] read_mux =
    (ADDR == port_write_retry_pkg::REPORT_RETRY_TIMEOUT_ADDR)  ? retry_reg :
    (ADDR == port_write_retry_pkg::EVENT_PIN_CONTROL_ADDR)     ? pin_reg :
    (ADDR == port_write_retry_pkg::PENDING_REPORT_STATUS_ADDR) ? 32'(pending_report_per_port) :
    (ADDR == port_write_retry_pkg::IRQ_STATUS_ADDR)            ? 32'(irq_status) :
    (ADDR == port_write_retry_pkg::IRQ_MASK_ADDR)              ? 32'(irq_mask) :
    32'h0000_0000;

  // ==========================================================================
  // Event sources
  wire logic pin_rise  = MC_EVENT_PIN_I && !pin_prev;
  wire logic pin_trig  = (event_pin_direction == port_write_retry_pkg::PIN_IN) && pin_rise;
  wire logic pin_drive = (event_pin_direction == port_write_retry_pkg::PIN_OUT) && SYM_RECEIVED;
  wire logic send_now  = ERR_EVENT || (retry_fire && report_pending);

  // Port taken by the arbiter in this cycle
  wire logic [PORTS-1:0] sent_mask =
    ARB_SENT.sent ? (PORTS'(1) << ARB_SENT.port) : {PORTS{1'b0}};

  // Status events; a set in the same cycle as a read-clear survives
  wire logic [port_write_retry_pkg::IRQ_W-1:0] irq_events = {pin_drive, pin_trig, send_now};
  wire logic [port_write_retry_pkg::IRQ_W-1:0] next_irq_status =
    (rd_irq ? {port_write_retry_pkg::IRQ_W{1'b0}} : irq_status) | irq_events;

  // ==========================================================================
  // Retry timer
  retry_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_timer (
    .clk    (CLK_SYS),
    .reset  (RESET),
    .enable (report_pending),
    .code   (retry_interval_code),
    .fire   (retry_fire)
  );

  // ==========================================================================
  // Software registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      retry_reg <= port_write_retry_pkg::REPORT_RETRY_TIMEOUT_RST;
      pin_reg   <= port_write_retry_pkg::EVENT_PIN_CONTROL_RST;
      irq_mask  <= port_write_retry_pkg::IRQ_RST;
    end else begin
      if (wr_retry) retry_reg <= WR_DATA & retry_wmask;
      if (wr_pin) pin_reg <= WR_DATA & pin_wmask;
      if (wr_mask) irq_mask <= WR_DATA[port_write_retry_pkg::IRQ_W-1:0];
    end
  end

  // Pending report: a new error wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RESET) report_pending <= 1'b0;
    else report_pending <= ERR_EVENT || (report_pending && !wr_clear);
  end

  // Per-port waiting requests, refreshed after every send
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pending_report_per_port <= port_write_retry_pkg::PENDING_STATUS_RST;
    end else if (ARB_SENT.sent) begin
      pending_report_per_port <= (pending_report_per_port | PW_REQ) & ~sent_mask;
    end
  end

  // Interrupt status and level output
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_status <= port_write_retry_pkg::IRQ_RST;
      IRQ        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      IRQ        <= |(next_irq_status & irq_mask);
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge CLK_SYS) begin
    if (RESET) RD_DATA <= 32'h0000_0000;
    else RD_DATA <= RD_EN ? read_mux : 32'h0000_0000;
  end

  // Port-write request toward the fabric
  always_ff @(posedge CLK_SYS) begin
    if (RESET) PW_SEND <= 1'b0;
    else PW_SEND <= send_now;
  end

  // Event pin; with direction 00 or 11 the pin is neither read nor driven
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pin_prev        <= 1'b0;
      SYM_GENERATE    <= 1'b0;
      MC_EVENT_PIN_O  <= 1'b0;
      MC_EVENT_PIN_OE <= 1'b0;
    end else begin
      pin_prev        <= MC_EVENT_PIN_I;
      SYM_GENERATE    <= pin_trig;
      MC_EVENT_PIN_O  <= pin_drive;
      MC_EVENT_PIN_OE <= event_pin_direction == port_write_retry_pkg::PIN_OUT;
    end
  end

  // ==========================================================================
  // Checks
  a_first_send: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ERR_EVENT |=> PW_SEND ##0 report_pending)
    else $error("error event did not send a report");

  a_retry_send: assert property (@(posedge CLK_SYS) disable iff (RESET)
    retry_fire && report_pending |=> PW_SEND)
    else $error("timer expiry did not resend the report");

  a_clear_stops: assert property (@(posedge CLK_SYS) disable iff (RESET)
    wr_clear && !ERR_EVENT |=> !report_pending ##1 !report_pending || $past(ERR_EVENT))
    else $error("clear did not stop the pending report");

  a_status_update: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ARB_SENT.sent |=> pending_report_per_port ==
      (($past(pending_report_per_port) | $past(PW_REQ)) & ~$past(sent_mask)))
    else $error("pending vector not updated after a send");

  a_sent_cleared: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ARB_SENT.sent |=> !pending_report_per_port[$past(ARB_SENT.port)])
    else $error("sent port still marked pending");

  a_status_layout: assert property (@(posedge CLK_SYS) disable iff (RESET)
    RD_EN && ADDR == port_write_retry_pkg::PENDING_REPORT_STATUS_ADDR
      |=> RD_DATA[31:PORTS] == '0 && RD_DATA[PORTS-1:0] == $past(pending_report_per_port))
    else $error("pending vector read wrong");

  a_pin_off: assert property (@(posedge CLK_SYS) disable iff (RESET)
    event_pin_direction == port_write_retry_pkg::PIN_OFF |=> !SYM_GENERATE && !MC_EVENT_PIN_OE)
    else $error("event pin active while disabled");

  a_pin_input: assert property (@(posedge CLK_SYS) disable iff (RESET)
    event_pin_direction == port_write_retry_pkg::PIN_IN && MC_EVENT_PIN_I && !pin_prev
      |=> SYM_GENERATE && !MC_EVENT_PIN_OE)
    else $error("pin edge did not trigger a symbol");

  a_pin_output: assert property (@(posedge CLK_SYS) disable iff (RESET)
    event_pin_direction == port_write_retry_pkg::PIN_OUT && SYM_RECEIVED
      |=> MC_EVENT_PIN_OE && MC_EVENT_PIN_O)
    else $error("received symbol not driven on the pin");

  a_irq_level: assert property (@(posedge CLK_SYS) disable iff (RESET)
    IRQ |-> |($past(next_irq_status) & $past(irq_mask)))
    else $error("interrupt without unmasked status");

endmodule : port_write_retry

// file: far_side_model.sv
// Far-side model: port-write receiver and external event pin source
`timescale 1ns/1ps
module far_side_model (
  input  wire logic clk,
  input  wire logic pw_send,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_level,
  output int        pw_count
);
  logic drive;

  // ==========================================================================
  // Pin wire: the device wins only while its enable is high
  assign pin_level = pin_oe ? pin_o : drive;

  // Start quiet so the first edge seen is a real one
  initial begin
    drive = 1'b0;
    pw_count = 0;
  end

  // Every port-write pulse is one report received
  always @(posedge clk) begin
    if (pw_send === 1'b1) pw_count <= pw_count + 1;
  end

  // External source changes the pin just after an edge
  task automatic set_pin(input logic v);
    @(posedge clk);
    drive <= v;
  endtask : set_pin
endmodule : far_side_model

// file: port_write_retry_tb_top.sv
// Self-checking testbench for the port-write retry and event pin block
`timescale 1ns/1ps
module port_write_retry_tb_top;
  // Short base unit keeps the retry runs brief
  localparam int UNIT = 20;
  localparam logic [16:0] A_PIN = port_write_retry_pkg::EVENT_PIN_CONTROL_ADDR;
  localparam logic [16:0] A_TMO = port_write_retry_pkg::REPORT_RETRY_TIMEOUT_ADDR;
  localparam logic [16:0] A_PND = port_write_retry_pkg::PENDING_REPORT_STATUS_ADDR;
  localparam logic [16:0] A_CLR = port_write_retry_pkg::ERROR_DETECT_CLEAR_ADDR;
  localparam logic [16:0] A_STS = port_write_retry_pkg::IRQ_STATUS_ADDR;
  localparam logic [16:0] A_MSK = port_write_retry_pkg::IRQ_MASK_ADDR;
  logic                            CLK_SYS = 1'b0;
  logic                            RESET = 1'b1;
  logic [16:0]                     ADDR = '0;
  logic [31:0]                     WR_DATA = '0;
  logic                            WR_EN = 1'b0;
  logic                            RD_EN = 1'b0;
  logic [31:0]                     RD_DATA;
  logic                            IRQ;
  logic                            ERR_EVENT = 1'b0;
  logic                            PW_SEND;
  logic [7:0]                      PW_REQ = '0;
  port_write_retry_pkg::arb_sent_s ARB_SENT = '0;
  logic                            SYM_RECEIVED = 1'b0;
  logic                            SYM_GENERATE;
  logic                            MC_EVENT_PIN_O;
  logic                            MC_EVENT_PIN_OE;
  logic                            pin_level;
  int                              pw_count;
  int                              bad_count = 0;
  int                              checks_done = 0;

  // ==========================================================================
  // Clock, device and far side
  always #5 CLK_SYS = ~CLK_SYS;

  port_write_retry #(.UNIT_CYCLES(UNIT)) uut (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .IRQ(IRQ),
    .ERR_EVENT(ERR_EVENT), .PW_SEND(PW_SEND), .PW_REQ(PW_REQ),
    .ARB_SENT(ARB_SENT), .SYM_RECEIVED(SYM_RECEIVED),
    .SYM_GENERATE(SYM_GENERATE), .MC_EVENT_PIN_I(pin_level),
    .MC_EVENT_PIN_O(MC_EVENT_PIN_O), .MC_EVENT_PIN_OE(MC_EVENT_PIN_OE));

  far_side_model far (.clk(CLK_SYS), .pw_send(PW_SEND), .pin_o(MC_EVENT_PIN_O),
    .pin_oe(MC_EVENT_PIN_OE), .pin_level(pin_level), .pw_count(pw_count));

  // ==========================================================================
  // Shared tasks
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : cyc

  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WR_DATA <= d;
    WR_EN <= 1'b1;
    @(posedge CLK_SYS);
    WR_EN <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [16:0] a, input logic [31:0] exp);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge CLK_SYS);
    RD_EN <= 1'b0;
    #1 chk(what, RD_DATA, exp);
  endtask : rchk

  task automatic pulse(input bit err);
    @(posedge CLK_SYS);
    if (err) ERR_EVENT <= 1'b1;
    else SYM_RECEIVED <= 1'b1;
    @(posedge CLK_SYS);
    ERR_EVENT <= 1'b0;
    SYM_RECEIVED <= 1'b0;
    #1;
  endtask : pulse

  // Cycles up to the next send; a lost retry ends the run
  task automatic gap(output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (PW_SEND !== 1'b1 && n < 400);
    if (n >= 400) begin
      bad_count++;
      results();
    end
  endtask : gap

  task automatic arb(input logic [7:0] req, input logic [2:0] port);
    @(posedge CLK_SYS);
    PW_REQ <= req;
    ARB_SENT <= '{sent: 1'b1, port: port};
    @(posedge CLK_SYS);
    ARB_SENT.sent <= 1'b0;
  endtask : arb

  // Count symbol requests over one pin pulse
  task automatic gens(output int n);
    n = 0;
    far.set_pin(1'b1);
    repeat (4) begin
      cyc(1);
      if (SYM_GENERATE === 1'b1) n++;
    end
    far.set_pin(1'b0);
    cyc(3);
  endtask : gens

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rchk("pin ctl reset", A_PIN, 32'h0000_0000);
    rchk("timeout reset", A_TMO, 32'h0000_0000);
    rchk("pending reset", A_PND, 32'h0000_0000);
    rchk("unmapped", 17'h1AC30, 32'h0000_0000);
    wr(A_TMO, 32'hFFFF_FFFF);
    rchk("timeout rw", A_TMO, 32'hF000_0000);
    wr(A_TMO, 32'h0000_0000);
    wr(A_PIN, 32'hDFFF_FFFF);
    rchk("pin ctl rw", A_PIN, 32'h1000_0000);
    wr(A_PIN, 32'h0000_0000);
    $display("register test done");
  endtask : t_regs

  task automatic t_pending;
    arb(8'hA5, 3'h0);
    rchk("pending port0 sent", A_PND, 32'h0000_00A4);
    arb(8'h00, 3'h2);
    rchk("pending port2 sent", A_PND, 32'h0000_00A0);
    arb(8'h00, 3'h7);
    rchk("pending port7 sent", A_PND, 32'h0000_0020);
    arb(8'h02, 3'h5);
    rchk("pending merge", A_PND, 32'h0000_0002);
    wr(A_PND, 32'hFFFF_FFFF);
    rchk("pending read only", A_PND, 32'h0000_0002);
    $display("pending test done");
  endtask : t_pending

  task automatic t_pin;
    int n;
    gens(n);
    chk("gen when off", n, 0);
    pulse(1'b0);
    chk("drive when off", MC_EVENT_PIN_O, 0);
    chk("oe when off", MC_EVENT_PIN_OE, 0);
    wr(A_PIN, 32'h1000_0000);
    gens(n);
    chk("gen when input", n, 1);
    chk("oe when input", MC_EVENT_PIN_OE, 0);
    wr(A_PIN, 32'h2000_0000);
    cyc(2);
    chk("oe when output", MC_EVENT_PIN_OE, 1);
    pulse(1'b0);
    chk("pin driven", pin_level, 1);
    cyc(1);
    chk("pin pulse end", MC_EVENT_PIN_O, 0);
    gens(n);
    chk("gen when output", n, 0);
    wr(A_PIN, 32'h0000_0000);
    $display("pin test done");
  endtask : t_pin

  task automatic t_once;
    int c0;
    wr(A_MSK, 32'h0000_0000);
    rchk("status flush", A_STS, 32'h0000_0006);
    c0 = pw_count;
    pulse(1'b1);
    cyc(200);
    chk("single send", pw_count - c0, 1);
    chk("masked irq", IRQ, 0);
    rchk("status sent", A_STS, 32'h0000_0001);
    rchk("status cleared", A_STS, 32'h0000_0000);
    wr(A_MSK, 32'h0000_0001);
    pulse(1'b1);
    cyc(3);
    chk("irq raised", IRQ, 1);
    rchk("status again", A_STS, 32'h0000_0001);
    cyc(2);
    chk("irq cleared", IRQ, 0);
    $display("single send test done");
  endtask : t_once

  task automatic t_retry;
    logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
    int p;
    int n;
    int c0;
    // Drop the report left pending earlier, else the timer loads before the pulse
    wr(A_CLR, 32'h0000_0001);
    foreach (codes[i]) begin
      p = (codes[i] == 4'hF) ? port_write_retry_pkg::DEBUG_CYCLES
        : codes[i] * UNIT + port_write_retry_pkg::EXTRA_CYCLES;
      wr(A_TMO, {codes[i], 28'h0});
      pulse(1'b1);
      chk("first send", PW_SEND, 1);
      gap(n);
      chk("retry period", n, p);
      gap(n);
      chk("restart period", n, p);
      wr(A_CLR, 32'h0000_0001);
      c0 = pw_count;
      cyc(p + 10);
      chk("sends after clear", pw_count - c0, 0);
    end
    $display("retry test done");
  endtask : t_retry

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RESET <= 1'b0;
    t_regs();
    t_pending();
    t_pin();
    t_once();
    t_retry();
    results();
  end
endmodule : port_write_retry_tb_top
